// >>> prf_fifo.sv
// flip-flop fifo with flush, occupancy count and look-ahead head word
`timescale 1ns/1ps
`default_nettype none
module prf_fifo #(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CW    = 5
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    input  wire logic          push_i,
    input  wire logic [W-1:0]  push_data_i,
    input  wire logic          pop_i,
    input  wire logic          flush_i,
    output logic      [W-1:0]  head_o,
    output logic               full_o,
    output logic               empty_o,
    output logic      [CW-1:0] count_o
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } prf_fifo_st_s;

    prf_fifo_st_s st_q;
    prf_fifo_st_s st_d;
    logic         do_push;
    logic         do_pop;

    assign full_o  = (st_q.cnt == CW'(DEPTH));
    assign empty_o = (st_q.cnt == '0);
    assign head_o  = st_q.mem[st_q.rp];
    assign count_o = st_q.cnt;
    // overflow and underflow are dropped rather than corrupting the pointers
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;

    always_comb begin
        st_d = st_q;
        if (flush_i) begin
            st_d.wp  = '0;
            st_d.rp  = '0;
            st_d.cnt = '0;
        end else begin
            if (do_push) begin
                st_d.mem[st_q.wp] = push_data_i;
                st_d.wp           = st_q.wp + PW'(1);
            end
            if (do_pop) begin
                st_d.rp = st_q.rp + PW'(1);
            end
            st_d.cnt = st_q.cnt + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// >>> prf_pkg.sv
// shared constants, carriers and lane helpers for the process ram fifo transfer engine
package prf_pkg;

    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned HB_AW      = 12;
    localparam int unsigned RAM_AW     = 16;
    localparam int unsigned CNT_W      = 5;

    // host bus byte offsets; fifo ports answer on eight word aliases each
    localparam logic [HB_AW-1:0] OFF_UP_FIFO     = 12'h000;
    localparam logic [HB_AW-1:0] OFF_DN_FIFO     = 12'h020;
    localparam logic [HB_AW-1:0] OFF_UP_ADDR_LEN = 12'h308;
    localparam logic [HB_AW-1:0] OFF_UP_CMD      = 12'h30c;
    localparam logic [HB_AW-1:0] OFF_DN_ADDR_LEN = 12'h310;
    localparam logic [HB_AW-1:0] OFF_DN_CMD      = 12'h314;
    localparam int unsigned      ALIAS_LSB       = 5;

    // field layout of address/length and command registers
    localparam int unsigned ADDR_LSB      = 0;
    localparam int unsigned LEN_LSB       = 16;
    localparam int unsigned CMD_BUSY_BIT  = 31;
    localparam int unsigned CMD_ABORT_BIT = 30;
    localparam int unsigned CMD_CNT_LSB   = 8;
    localparam int unsigned CMD_AVAIL_BIT = 0;

    localparam logic [RAM_AW-1:0] RST_ADDR  = 16'h0000;
    localparam logic [RAM_AW-1:0] RST_LEN   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
    localparam logic [1:0]        WORD_LANE = 2'h0;

    typedef enum logic [2:0] {
        PRF_RAM_IDLE = 3'b001,
        PRF_RAM_RD   = 3'b010,
        PRF_RAM_WR   = 3'b100
    } prf_ram_e;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              direct;
        logic [HB_AW-1:0]  addr;
        logic [DATA_W-1:0] wdata;
    } prf_hb_req_s;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [RAM_AW-1:0] addr;
        logic [3:0]        be;
        logic [DATA_W-1:0] wdata;
    } prf_ram_req_s;

    // bytes taken from the word that holds lo, never crossing into the next word
    function automatic logic [2:0] prf_lane_count(input logic [1:0] lo, input logic [15:0] len);
        logic [2:0] room;
        room = 3'h4 - {1'b0, lo};
        if (len < {13'h0000, room}) begin
            return len[2:0];
        end
        return room;
    endfunction

    function automatic logic [3:0] prf_lane_mask(input logic [1:0] lo, input logic [15:0] len);
        logic [7:0] m;
        m = ((8'h01 << prf_lane_count(lo, len)) - 8'h01) << lo;
        return m[3:0];
    endfunction

endpackage

// >>> prf_ram_model.sv
// core ram model with adjustable acknowledge delay
`timescale 1ns/1ps
`default_nettype none
module prf_ram_model (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire prf_pkg::prf_ram_req_s ram_i,
    input  wire logic [1:0]            wait_i,
    output logic                       ack_o,
    output logic [31:0]                rdata_o
);
    import prf_pkg::*;
    logic [7:0] mem [0:4095];
    logic [1:0] cnt;
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7 + 3);
    // read lines toggle outside acks so a stale word never looks fresh
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            cnt <= 2'h0;
            rdata_o <= 32'h0;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (ram_i.req && !ack_o) begin
                cnt <= cnt + 2'h1;
                if (cnt >= wait_i) begin
                    cnt <= 2'h0;
                    ack_o <= 1'b1;
                    for (int b = 0; b < 4; b++) begin
                        rdata_o[8*b+:8] <= mem[{ram_i.addr[11:2], 2'(b)}];
                        if (ram_i.we && ram_i.be[b]) begin
                            mem[{ram_i.addr[11:2], 2'(b)}] <= ram_i.wdata[8*b+:8];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> prf_transfer.sv
// process ram transfer engine: host register port, two fifos and core ram port
`timescale 1ns/1ps
`default_nettype none
module prf_transfer
    import prf_pkg::*;
#(
    parameter int unsigned DEPTH = prf_pkg::FIFO_DEPTH
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire prf_pkg::prf_hb_req_s  hb_i,
    output logic [prf_pkg::DATA_W-1:0] hb_rdata_o,
    output logic                       hb_rvalid_o,
    output prf_pkg::prf_ram_req_s      ram_o,
    input  wire logic                  ram_ack_i,
    input  wire logic [prf_pkg::DATA_W-1:0] ram_rdata_i
);
    import prf_pkg::*;

    typedef struct packed {
        logic [RAM_AW-1:0] up_addr;
        logic [RAM_AW-1:0] up_len;
        logic [RAM_AW-1:0] dn_addr;
        logic [RAM_AW-1:0] dn_len;
        logic              up_busy;
        logic              dn_busy;
        prf_ram_e          ram_st;
        logic              drop;
        prf_ram_req_s      ram;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
    } prf_st_s;

    prf_st_s           st_q;
    prf_st_s           st_d;

    logic [DATA_W-1:0] up_head;
    logic [DATA_W-1:0] dn_head;
    logic              up_full;
    logic              up_empty;
    logic              dn_full;
    logic              dn_empty;
    logic [CNT_W-1:0]  up_cnt;
    logic [CNT_W-1:0]  dn_cnt;
    logic [CNT_W-1:0]  dn_space;

    logic              sel_up_fifo;
    logic              sel_dn_fifo;
    logic              up_pop;
    logic              dn_push;
    logic              up_push;
    logic              dn_pop;
    logic              up_flush;
    logic              dn_flush;
    logic              up_abort;
    logic              dn_abort;
    logic              up_start;
    logic              dn_start;
    logic              up_go;
    logic              dn_go;
    logic              ack_rd;
    logic              ack_wr;
    logic [DATA_W-1:0] up_cmd_word;
    logic [DATA_W-1:0] dn_cmd_word;

    function automatic logic alias_hit(input logic [HB_AW-1:0] a, input logic [HB_AW-1:0] base);
        return a[HB_AW-1:ALIAS_LSB] == base[HB_AW-1:ALIAS_LSB];
    endfunction

    function automatic logic cmd_write(input prf_hb_req_s r, input logic [HB_AW-1:0] off);
        return r.wr && !r.direct && (r.addr == off);
    endfunction

    // direct selection ignores the address bus altogether
    assign sel_up_fifo = hb_i.direct || alias_hit(hb_i.addr, OFF_UP_FIFO);
    assign sel_dn_fifo = hb_i.direct || alias_hit(hb_i.addr, OFF_DN_FIFO);

    // any read of the port pops a full word, partial lanes or not
    assign up_pop  = hb_i.rd && sel_up_fifo && !up_empty;
    assign dn_push = hb_i.wr && sel_dn_fifo;

    assign up_start = cmd_write(hb_i, OFF_UP_CMD) && hb_i.wdata[CMD_BUSY_BIT];
    assign dn_start = cmd_write(hb_i, OFF_DN_CMD) && hb_i.wdata[CMD_BUSY_BIT];
    assign up_abort = cmd_write(hb_i, OFF_UP_CMD) && hb_i.wdata[CMD_ABORT_BIT];
    assign dn_abort = cmd_write(hb_i, OFF_DN_CMD) && hb_i.wdata[CMD_ABORT_BIT];

    assign ack_rd = ram_ack_i && (st_q.ram_st == PRF_RAM_RD);
    assign ack_wr = ram_ack_i && (st_q.ram_st == PRF_RAM_WR);

    // one outstanding ram access; upload wins ties since host reads wait on it
    assign up_go = st_q.up_busy && !up_abort && (st_q.up_len != RST_LEN) && !up_full
                   && (st_q.ram_st == PRF_RAM_IDLE);
    assign dn_go = st_q.dn_busy && !dn_abort && (st_q.dn_len != RST_LEN) && !dn_empty
                   && (st_q.ram_st == PRF_RAM_IDLE) && !up_go;

    assign up_push = ack_rd && !st_q.drop;
    assign dn_pop  = dn_go;
    assign up_flush = up_abort;
    // leftover words after completion are stale for the next transfer
    assign dn_flush = dn_abort || (st_q.dn_busy && (st_q.dn_len == RST_LEN)
                      && (st_q.ram_st != PRF_RAM_WR));

    assign dn_space = CNT_W'(DEPTH) - dn_cnt;

    always_comb begin
        up_cmd_word                           = RST_WORD;
        up_cmd_word[CMD_BUSY_BIT]             = st_q.up_busy;
        up_cmd_word[CMD_CNT_LSB +: CNT_W]     = up_cnt;
        up_cmd_word[CMD_AVAIL_BIT]            = !up_empty;
        dn_cmd_word                           = RST_WORD;
        dn_cmd_word[CMD_BUSY_BIT]             = st_q.dn_busy;
        dn_cmd_word[CMD_CNT_LSB +: CNT_W]     = dn_space;
        dn_cmd_word[CMD_AVAIL_BIT]            = !dn_full;
    end

    prf_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH),
        .CW    (CNT_W)
    ) u_up_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .push_i      (up_push),
        .push_data_i (ram_rdata_i),
        .pop_i       (up_pop),
        .flush_i     (up_flush),
        .head_o      (up_head),
        .full_o      (up_full),
        .empty_o     (up_empty),
        .count_o     (up_cnt)
    );

    prf_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH),
        .CW    (CNT_W)
    ) u_dn_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .push_i      (dn_push),
        .push_data_i (hb_i.wdata),
        .pop_i       (dn_pop),
        .flush_i     (dn_flush),
        .head_o      (dn_head),
        .full_o      (dn_full),
        .empty_o     (dn_empty),
        .count_o     (dn_cnt)
    );

    always_comb begin
        st_d        = st_q;
        st_d.rvalid = hb_i.rd;
        st_d.rdata  = RST_WORD;

        // register read mux; unmapped offsets read zero
        if (hb_i.rd) begin
            if (sel_up_fifo) begin
                st_d.rdata = up_empty ? RST_WORD : up_head;
            end else if (hb_i.addr == OFF_UP_ADDR_LEN) begin
                st_d.rdata = {st_q.up_len, st_q.up_addr};
            end else if (hb_i.addr == OFF_UP_CMD) begin
                st_d.rdata = up_cmd_word;
            end else if (hb_i.addr == OFF_DN_ADDR_LEN) begin
                st_d.rdata = {st_q.dn_len, st_q.dn_addr};
            end else if (hb_i.addr == OFF_DN_CMD) begin
                st_d.rdata = dn_cmd_word;
            end
        end

        if (cmd_write(hb_i, OFF_UP_ADDR_LEN)) begin
            st_d.up_addr = hb_i.wdata[ADDR_LSB +: RAM_AW];
            st_d.up_len  = hb_i.wdata[LEN_LSB +: RAM_AW];
        end
        if (cmd_write(hb_i, OFF_DN_ADDR_LEN)) begin
            st_d.dn_addr = hb_i.wdata[ADDR_LSB +: RAM_AW];
            st_d.dn_len  = hb_i.wdata[LEN_LSB +: RAM_AW];
        end

        // ram completion: advance the direction that owned the access
        if (ack_rd) begin
            st_d.ram_st  = PRF_RAM_IDLE;
            st_d.ram.req = 1'b0;
            st_d.drop    = 1'b0;
            if (!st_q.drop) begin
                st_d.up_addr = st_q.up_addr
                               + RAM_AW'(prf_lane_count(st_q.up_addr[1:0], st_q.up_len));
                st_d.up_len  = st_q.up_len
                               - RAM_AW'(prf_lane_count(st_q.up_addr[1:0], st_q.up_len));
            end
        end
        if (ack_wr) begin
            st_d.ram_st  = PRF_RAM_IDLE;
            st_d.ram.req = 1'b0;
            st_d.drop    = 1'b0;
            if (!st_q.drop) begin
                st_d.dn_addr = st_q.dn_addr
                               + RAM_AW'(prf_lane_count(st_q.dn_addr[1:0], st_q.dn_len));
                st_d.dn_len  = st_q.dn_len
                               - RAM_AW'(prf_lane_count(st_q.dn_addr[1:0], st_q.dn_len));
            end
        end

        // lanes: from the address lane up, stopping at the word end or the transfer end
        if (up_go) begin
            st_d.ram_st    = PRF_RAM_RD;
            st_d.ram.req   = 1'b1;
            st_d.ram.we    = 1'b0;
            st_d.ram.addr  = {st_q.up_addr[RAM_AW-1:2], WORD_LANE};
            st_d.ram.be    = prf_lane_mask(st_q.up_addr[1:0], st_q.up_len);
            st_d.ram.wdata = RST_WORD;
        end else if (dn_go) begin
            st_d.ram_st    = PRF_RAM_WR;
            st_d.ram.req   = 1'b1;
            st_d.ram.we    = 1'b1;
            st_d.ram.addr  = {st_q.dn_addr[RAM_AW-1:2], WORD_LANE};
            st_d.ram.be    = prf_lane_mask(st_q.dn_addr[1:0], st_q.dn_len);
            st_d.ram.wdata = dn_head;
        end

        // upload ends once its last word has left the fifo
        if (st_q.up_busy && (st_q.up_len == RST_LEN) && (st_q.ram_st != PRF_RAM_RD)
            && up_empty) begin
            st_d.up_busy = 1'b0;
        end
        // download ends when the last ram write is acknowledged, or on abort
        if (st_q.dn_busy && (st_q.dn_len == RST_LEN) && (st_q.ram_st != PRF_RAM_WR)) begin
            st_d.dn_busy = 1'b0;
        end

        if (up_start) begin
            st_d.up_busy = 1'b1;
        end
        if (dn_start) begin
            st_d.dn_busy = 1'b1;
        end

        // an access already on the ram port is allowed to finish but its result is dropped
        if (up_abort) begin
            st_d.up_busy = 1'b0;
            if (st_q.ram_st == PRF_RAM_RD && !ack_rd) begin
                st_d.drop = 1'b1;
            end
        end
        if (dn_abort) begin
            st_d.dn_busy = 1'b0;
            if (st_q.ram_st == PRF_RAM_WR && !ack_wr) begin
                st_d.drop = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q         <= '0;
            st_q.up_addr <= RST_ADDR;
            st_q.up_len  <= RST_LEN;
            st_q.dn_addr <= RST_ADDR;
            st_q.dn_len  <= RST_LEN;
            st_q.ram_st  <= PRF_RAM_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign hb_rdata_o  = st_q.rdata;
    assign hb_rvalid_o = st_q.rvalid;
    assign ram_o       = st_q.ram;

    property p_up_depth;
        @(posedge mclk_i) disable iff (rst_i)
        up_cnt <= CNT_W'(DEPTH);
    endproperty
    a_up_depth: assert property (p_up_depth)
        else $error("upload fifo above depth");

    property p_alias_read;
        @(posedge mclk_i) disable iff (rst_i)
        (hb_i.rd && !hb_i.direct && hb_i.addr[HB_AW-1:ALIAS_LSB] == OFF_UP_FIFO[HB_AW-1:ALIAS_LSB]
         && !up_empty) |-> up_pop ##1 (hb_rvalid_o && hb_rdata_o == $past(up_head));
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("upload alias read did not return head word");

    property p_direct_read;
        @(posedge mclk_i) disable iff (rst_i)
        (hb_i.rd && hb_i.direct && !up_empty) |-> up_pop;
    endproperty
    a_direct_read: assert property (p_direct_read)
        else $error("direct read did not reach upload fifo");

    property p_up_done;
        @(posedge mclk_i) disable iff (rst_i)
        (st_q.up_busy && st_q.up_len == RST_LEN && st_q.ram_st == PRF_RAM_IDLE && up_empty
         && !hb_i.wr) |=> !st_q.up_busy;
    endproperty
    a_up_done: assert property (p_up_done)
        else $error("upload busy not cleared after last read");

    property p_up_progress;
        @(posedge mclk_i) disable iff (rst_i)
        (ack_rd && !st_q.drop && !hb_i.wr) |=>
        (st_q.up_len + st_q.up_addr == $past(st_q.up_len) + $past(st_q.up_addr))
        && (st_q.up_len < $past(st_q.up_len));
    endproperty
    a_up_progress: assert property (p_up_progress)
        else $error("upload length and address not advanced together");

    property p_lane_top;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(ram_o.req) |-> (ram_o.be != 4'h0) && (ram_o.addr[1:0] == WORD_LANE);
    endproperty
    a_lane_top: assert property (p_lane_top)
        else $error("ram access with no lanes or unaligned address");

    property p_abort_up;
        @(posedge mclk_i) disable iff (rst_i)
        up_abort |=> (!st_q.up_busy && up_empty) ##1 !(ram_o.req && !ram_o.we && $rose(ram_o.req));
    endproperty
    a_abort_up: assert property (p_abort_up)
        else $error("upload abort did not stop the transfer");

    property p_ram_busy;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(ram_o.req) |-> (ram_o.we ? $past(st_q.dn_busy) : $past(st_q.up_busy));
    endproperty
    a_ram_busy: assert property (p_ram_busy)
        else $error("ram access started without busy");

    property p_dn_done;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(st_q.dn_busy) |-> ($past(dn_abort) || $past(st_q.dn_len) == RST_LEN);
    endproperty
    a_dn_done: assert property (p_dn_done)
        else $error("download busy cleared before ram write finished");

    // a host write lands exactly when space was shown, and is dropped otherwise
    property p_dn_space;
        @(posedge mclk_i) disable iff (rst_i)
        (dn_push && !dn_pop && !dn_flush) |=>
        (dn_cnt == $past(dn_cnt) + CNT_W'($past(dn_cmd_word[CMD_AVAIL_BIT])));
    endproperty
    a_dn_space: assert property (p_dn_space)
        else $error("download space count inconsistent");
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the process ram fifo transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prf_pkg::*;
    localparam int UA[9] = '{'h1001, 'h1000, 'h1002, 'h1003, 'h1001, 'h1000, 'h1002, 'h1003, 'h1001};
    localparam int UL[9] = '{5, 1, 2, 1, 3, 4, 11, 6, 80};
    localparam int DA[8] = '{'h1801, 'h1810, 'h1822, 'h1833, 'h1841, 'h1850, 'h1862, 'h1873};
    localparam int DL[8] = '{5, 1, 2, 1, 3, 4, 11, 9};
    logic         mclk_i = 1'b0;
    logic         rst_i = 1'b1;
    prf_hb_req_s  hb = '0;
    logic [31:0]  rdata;
    logic         rvalid;
    prf_ram_req_s ram;
    logic         ack;
    logic [31:0]  ram_rdata;
    logic [1:0]   wt = 2'h0;
    logic [31:0]  v;
    logic [3:0]   beq[$];
    int           fails = 0;
    int           n_tests = 0;

    always #12.5 mclk_i = ~mclk_i;
    prf_transfer u_prf_transfer (.mclk_i(mclk_i), .rst_i(rst_i), .hb_i(hb), .hb_rdata_o(rdata),
        .hb_rvalid_o(rvalid), .ram_o(ram), .ram_ack_i(ack), .ram_rdata_i(ram_rdata));
    prf_ram_model u_prf_ram_model (.mclk_i(mclk_i), .rst_i(rst_i), .ram_i(ram), .wait_i(wt),
        .ack_o(ack), .rdata_o(ram_rdata));
    always @(posedge mclk_i) if (ack && ram.req) beq.push_back(ram.be);

    function automatic logic [7:0] ib(int a);
        return 8'(a % 4096 * 7 + 3);
    endfunction
    function automatic logic [31:0] dw(int i);
        return 32'h5a3c_0f00 + 32'(i) * 32'h0111_1111;
    endfunction
    function automatic logic [3:0] lanes(int a, int n);
        for (int b = 0; b < 4; b++) lanes[b] = b >= a % 4 && b < a % 4 + n;
    endfunction

    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic dir = 1'b0);
        @(negedge mclk_i);
        hb = '{rd: 1'b0, wr: 1'b1, direct: dir, addr: a, wdata: d};
        @(negedge mclk_i);
        hb.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic dir = 1'b0);
        @(negedge mclk_i);
        hb = '{rd: 1'b1, wr: 1'b0, direct: dir, addr: a, wdata: 32'h0};
        @(negedge mclk_i);
        hb.rd = 1'b0;
        d = rvalid === 1'b1 ? rdata : 'x;
    endtask
    // bounded wait until the count field reaches n or busy drops
    task automatic poll(logic [11:0] a, int n);
        int t = 0;
        do begin
            rd(a, v);
            t++;
        end while (v[31] && v[12:8] < n && t < 500);
        chk("poll_wait", 1'b0, v[31] && v[12:8] < n);
    endtask

    task automatic up(int a, int len);
        int p = a;
        int r = len;
        int c;
        logic [31:0] e;
        logic [3:0] m;
        beq.delete();
        wr(OFF_UP_ADDR_LEN, {16'(len), 16'(a)});
        wr(OFF_UP_CMD, 32'h8000_0000);
        if (len > 64) begin
            poll(OFF_UP_CMD, 16);
            repeat (20) @(negedge mclk_i);
            rd(OFF_UP_CMD, v);
            chk("up_full", 32'h8000_1001, v);
        end
        while (r > 0) begin
            poll(OFF_UP_CMD, 1);
            chk("up_avail", 1'b1, v[0]);
            c = v[12:8];
            for (int i = 0; i < c && r > 0; i++) begin
                m = lanes(p, r);
                for (int b = 0; b < 4; b++) e[8*b+:8] = m[b] ? ib(p - p % 4 + b) : 8'h0;
                rd(i == 3 ? OFF_DN_CMD : 12'(4 * (i % 8)), v, i == 3);
                chk("up_data", e, v & {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}});
                chk("up_be", m, beq.pop_front());
                r -= 4 - p % 4;
                p += 4 - p % 4;
            end
        end
        rd(OFF_UP_ADDR_LEN, v);
        chk("up_pos", a + len, v);
        rd(OFF_UP_CMD, v);
        chk("up_done", 0, v);
    endtask

    task automatic dn(int a, int len);
        int p = a;
        int r = len;
        logic [7:0] e;
        beq.delete();
        wr(OFF_DN_ADDR_LEN, {16'(len), 16'(a)});
        wr(OFF_DN_CMD, 32'h8000_0000);
        for (int i = 0; i < (a % 4 + len + 3) / 4; i++) begin
            wr(i == 2 ? OFF_UP_ADDR_LEN : OFF_DN_FIFO + 12'(4 * i), dw(i), i == 2);
        end
        poll(OFF_DN_CMD, 32);
        chk("dn_busy", 1'b0, v[31]);
        for (int x = a - 1; x <= a + len; x++) begin
            e = 8'(dw((x - a + a % 4) / 4) >> (8 * (x % 4)));
            if (x < a || x >= a + len) e = ib(x);
            chk("dn_byte", e, u_prf_ram_model.mem[x % 4096]);
        end
        while (r > 0) begin
            chk("dn_be", lanes(p, r), beq.pop_front());
            r -= 4 - p % 4;
            p += 4 - p % 4;
        end
        rd(OFF_DN_ADDR_LEN, v);
        chk("dn_pos", a + len, v);
    endtask

    initial begin
        #(40000 * 25);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        rd(OFF_UP_CMD, v);
        chk("rst_up", 0, v);
        rd(OFF_DN_CMD, v);
        chk("rst_dn", 32'h0000_1001, v);
        rd(12'h100, v);
        chk("unmapped", 0, v);
        for (int i = 0; i < 9; i++) begin
            wt = 2'(i);
            up(UA[i], UL[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wt = 2'(i + 1);
            dn(DA[i], DL[i]);
        end
        // seventeenth write is dropped by a full fifo
        for (int i = 0; i < 17; i++) begin
            wr(OFF_DN_FIFO, dw(i));
            if (i == 2 || i == 16) begin
                rd(OFF_DN_CMD, v);
                chk("dn_space", i == 2 ? 32'h0000_0d01 : 32'h0, v);
            end
        end
        // start a long download on the full fifo, then cancel it in flight
        wr(OFF_DN_ADDR_LEN, {16'h00c8, 16'h1900});
        wr(OFF_DN_CMD, 32'h8000_0000);
        rd(OFF_DN_CMD, v);
        chk("dn_run", 1'b1, v[31]);
        wr(OFF_DN_CMD, 32'h4000_0000);
        rd(OFF_DN_CMD, v);
        chk("dn_abort", 32'h0000_1001, v);
        wt = 2'h3;
        wr(OFF_UP_ADDR_LEN, {16'd200, 16'h1100});
        wr(OFF_UP_CMD, 32'h8000_0000);
        poll(OFF_UP_CMD, 2);
        wr(OFF_UP_CMD, 32'h4000_0000);
        repeat (12) @(negedge mclk_i);
        chk("ab_req", 0, ram.req);
        rd(OFF_UP_CMD, v);
        chk("ab_cmd", 0, v);
        rd(OFF_UP_FIFO, v);
        chk("ab_flush", 0, v);
        print_verdict();
    end
endmodule
`default_nettype wire
